// ### pkg/core_control_pkg.sv
// Core control register package: offsets, bit positions, reset values.
// Assumes a classic Wishbone slave with 32-bit data, one register per word.
package core_control_pkg;
	// Register map (byte addresses)
	localparam logic [3:0] core_control_off = 4'h0;
	localparam logic [3:0] priority_in_off = 4'h4;
	localparam logic [3:0] priority_set_off = 4'h8;
	// Field positions in the core control word
	localparam int prog_space_visible_pos = 2;
	localparam int priority_level_bit3_pos = 3;
	// Field positions in the priority input word
	localparam int priority_field_lsb = 5;
	localparam int priority_field_msb = 7;
	// Reset values
	localparam logic [15:0] core_control_rst = 16'h0000;
	localparam logic [2:0] priority_field_rst = 3'h0;
	localparam logic [3:0] level_rst = 4'h0;
	localparam logic [31:0] read_data_rst = 32'h0000_0000;
	// Answer to an unmapped address
	localparam logic [31:0] unmapped_data = 32'h0000_0000;
endpackage

// ### rtl/core_control_register.sv
// Core control register: priority-extension status bit and program space
// visibility enable, reached over a classic Wishbone slave port.
// Assumes the interrupt controller pulses the priority-extension set input.
//
// Contract
// - Bits 15 to 4 and 1 to 0 of the register always read as zero.
// - Bit 3 reads one when the interrupt priority level is above 7, else zero.
// - The full priority level is bit 3 placed above the three-bit status field.
// - Bit 2 is a read/write visibility enable that resets to zero.
// - Program memory is not mapped into data space from one cycle after bit 2 goes to zero.
// - Program and data spaces stay separate; data reads of program memory pass only when enabled.
`timescale 1ns/100ps
module core_control_register (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Interrupt controller side
	input wire logic priority_raise_i,
	input wire logic [2:0] priority_level_field_i,
	// Program space visibility path
	input wire logic psv_access_i,
	output logic [3:0] cpu_priority_level_o,
	output logic prog_space_visible_o,
	output logic psv_map_en_o
);
	//****************************************************************
	// Register state
	//****************************************************************
	// Bus handshake
	logic ack_reg;
	logic ack_next;
	logic taken;
	logic wr;
	logic rd;
	// Core control bits
	logic priority_level_bit3_reg;
	logic priority_level_bit3_next;
	logic prog_space_visible_reg;
	logic prog_space_visible_next;
	// Priority field scratch word
	logic [2:0] priority_field_reg;
	logic [2:0] priority_field_next;
	// Read data
	logic [31:0] dat_reg;
	logic [31:0] dat_next;
	logic [15:0] core_word;
	// Derived outputs
	logic [3:0] level_reg;
	logic [3:0] level_next;
	logic map_reg;
	logic map_next;

	//****************************************************************
	// Address decode
	//****************************************************************
	// Shared by the write and read paths so both agree on the map
	function automatic logic addr_hit(input logic [3:0] adr, input logic [3:0] off);
		addr_hit = (adr == off);
	endfunction

	//****************************************************************
	// Bus handshake
	//****************************************************************
	// Registered ack: one wait state, never combinational from stb
	assign taken = cyc_i && stb_i && !ack_reg;
	// Writes need the low byte lane; the register lives there
	assign wr = taken && we_i && sel_i[0];
	assign rd = taken && !we_i;

	always_comb begin
		ack_next = taken;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
		end
	end

	//****************************************************************
	// Core control bits
	//****************************************************************
	always_comb begin
		priority_level_bit3_next = priority_level_bit3_reg;
		prog_space_visible_next = prog_space_visible_reg;
		if (wr && addr_hit(adr_i, core_control_pkg::core_control_off)) begin
			prog_space_visible_next = dat_i[core_control_pkg::prog_space_visible_pos];
			// Writing one clears; writing zero leaves the bit alone
			if (dat_i[core_control_pkg::priority_level_bit3_pos]) begin
				priority_level_bit3_next = 1'b0;
			end
		end
		// Set wins over a clear in the same cycle, so no raise is lost
		if (priority_raise_i) begin
			priority_level_bit3_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			priority_level_bit3_reg <=
				core_control_pkg::core_control_rst[core_control_pkg::priority_level_bit3_pos];
			prog_space_visible_reg <=
				core_control_pkg::core_control_rst[core_control_pkg::prog_space_visible_pos];
		end else begin
			priority_level_bit3_reg <= priority_level_bit3_next;
			prog_space_visible_reg <= prog_space_visible_next;
		end
	end

	//****************************************************************
	// Priority field scratch word
	//****************************************************************
	always_comb begin
		priority_field_next = priority_field_reg;
		if (wr && addr_hit(adr_i, core_control_pkg::priority_in_off)) begin
			priority_field_next = dat_i[core_control_pkg::priority_field_msb:
				core_control_pkg::priority_field_lsb];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			priority_field_reg <= core_control_pkg::priority_field_rst;
		end else begin
			priority_field_reg <= priority_field_next;
		end
	end

	//****************************************************************
	// Read data
	//****************************************************************
	// Implemented bits only; the rest are constant zero, so writes
	// to unimplemented positions have nowhere to land
	assign core_word = {12'h000, priority_level_bit3_reg, prog_space_visible_reg, 2'h0};

	always_comb begin
		dat_next = dat_reg;
		if (rd) begin
			if (addr_hit(adr_i, core_control_pkg::core_control_off)) begin
				dat_next = {16'h0000, core_word};
			end else if (addr_hit(adr_i, core_control_pkg::priority_in_off)) begin
				dat_next = {24'h00_0000, priority_field_reg, 5'h00};
			end else if (addr_hit(adr_i, core_control_pkg::priority_set_off)) begin
				// Level as of the previous cycle; a raise in flight shows later
				dat_next = {28'h000_0000, level_reg};
			end else begin
				dat_next = core_control_pkg::unmapped_data;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= core_control_pkg::read_data_rst;
		end else begin
			dat_reg <= dat_next;
		end
	end

	//****************************************************************
	// Derived outputs
	//****************************************************************
	always_comb begin
		// Extension bit sits above the three status field bits
		level_next = {priority_level_bit3_reg, priority_level_field_i};
		// Data-space window opens onto program memory only when enabled
		map_next = psv_access_i && prog_space_visible_reg;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_reg <= core_control_pkg::level_rst;
			map_reg <= 1'b0;
		end else begin
			level_reg <= level_next;
			map_reg <= map_next;
		end
	end

	//****************************************************************
	// Outputs
	//****************************************************************
	assign dat_o = dat_reg;
	assign ack_o = ack_reg;
	assign cpu_priority_level_o = level_reg;
	assign prog_space_visible_o = prog_space_visible_reg;
	assign psv_map_en_o = map_reg;
endmodule // core_control_register

// ### testbench/core_control_checker_assertions.sv
// Port checker, bound to the register; one clock, sync reset.
`timescale 1ns/100ps
module core_control_checker (
	input clk_i, rst_i, stb_i, we_i, ack_o, priority_raise_i,
	input psv_access_i, prog_space_visible_o, psv_map_en_o,
	input [3:0] adr_i, sel_i, cpu_priority_level_o,
	input [2:0] priority_level_field_i,
	input [31:0] dat_i, dat_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire rd = ack_o && !we_i && !adr_i, wr = ack_o && we_i && !adr_i && sel_i[0];
	wire b3 = cpu_priority_level_o[3], pv = prog_space_visible_o, up = priority_raise_i;
	a_ack_next: assert property (stb_i && !ack_o |=> ack_o) else $error("ack");
	a_pad_zero: assert property (rd |-> !dat_o[15:4] && !dat_o[1:0]) else $error("pad");
	a_psv_write: assert property (wr |=> pv == $past(dat_i[2])) else $error("psv");
	a_map_off: assert property (!pv && !$past(pv) |-> !psv_map_en_o) else $error("map");
	a_map_src: assert property (psv_map_en_o |-> $past(psv_access_i)) else $error("src");
	a_no_set: assert property ($rose(b3) |-> $past(up) || $past(up, 2)) else $error("set");
	a_clear_b3: assert property (wr && dat_i[3] && !up && !$past(up) |-> ##2 !b3) else $error("clr");
	a_level_field: assert property (cpu_priority_level_o[2:0] == $past(priority_level_field_i)) else $error("field");
	a_raise_b3: assert property (up |-> ##2 b3) else $error("raise");
endmodule // core_control_checker
bind core_control_register core_control_checker u_chk (.*);

// ### testbench/core_control_register_tb_top.sv
// Bench: Wishbone tasks, read queue, xorshift data.
`timescale 1ns/100ps
module core_control_register_tb_top;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, priority_raise_i = 0;
	logic psv_access_i = 0, ack_o, prog_space_visible_o, psv_map_en_o;
	logic [3:0] adr_i = 4'h0, sel_i = 4'hf, cpu_priority_level_o;
	logic [2:0] priority_level_field_i = 3'h0;
	logic [31:0] dat_i = 32'h0000_0000, dat_o, rs = 32'h0000_032e, q[$];
	int error_cnt = 0, num_checks = 0;
	core_control_register DUT (.*);
	always #5 clk_i = ~clk_i;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		return x ^ (x >> 17) ^ ((x ^ (x >> 17)) << 5);
	endfunction
	task automatic chk(input logic [31:0] s, e);
		num_checks++;
		error_cnt += int'(s !== e);
		if (s !== e) $display("Error %0t seen %h exp %h", $time, s, e);
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, priority_raise_i, psv_access_i} <= {2'b11, w, a, d, 1'b0, rs[0]};
		if (!w) q.push_back(d);
		do @(posedge clk_i); while (!ack_o);
		{cyc_i, stb_i, priority_level_field_i} <= {2'b00, rs[7:5]};
	endtask
	always @(posedge clk_i) begin
		logic [31:0] e;
		if (ack_o && !we_i) begin
			e = q.pop_front();
			chk(dat_o, e);
			if (adr_i == 4'h0) chk({31'h0000_0000, prog_space_visible_o}, {31'h0000_0000, e[2]});
			if (adr_i == 4'h0) chk({31'h0000_0000, psv_map_en_o}, {31'h0000_0000, psv_access_i && e[2]});
			if (adr_i == 4'h8) chk({28'h000_0000, cpu_priority_level_o}, e);
		end
	end
	task automatic complete_run(input int n);
		error_cnt += n;
		$display("Checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial #20000 complete_run(1);
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		wb(0, 4'h0, 32'h0000_0000);
		repeat (6) begin
			rs = xs(rs);
			wb(1, 4'h0, rs);
			wb(0, 4'h0, rs & 32'h0000_0004);
			wb(1, 4'h4, rs);
			wb(0, 4'h4, rs & 32'h0000_00e0);
		end
		$display("rw done");
		priority_raise_i <= 1;
		wb(0, 4'h0, rs & 32'h0000_0004 | 32'h0000_0008);
		wb(0, 4'h8, {28'h000_0000, 1'b1, rs[7:5]});
		wb(1, 4'h0, rs | 32'h0000_0008);
		wb(0, 4'h0, rs & 32'h0000_0004);
		wb(0, 4'h8, {28'h000_0000, 1'b0, rs[7:5]});
		wb(0, 4'hc, 32'h0000_0000);
		$display("clear done");
		@(posedge clk_i);
		complete_run(0);
	end
endmodule // core_control_register_tb_top
